/* File: logic/oag_pkg.sv */
// Shared types, constants and decode helpers for operand/address generation
// Functional notes
// - 5-bit ordinal literal widened with zeros to 32
// - Wider operands also zero-extend the literal
// - Literal is never sign-extended for integers
// - Only +0.0/+1.0 float literals, float ops only
// - Float registers only with float instructions
// - Literal/register modes non-memory; address modes memory
// - Short-offset absolute address is zero-extended offset
// - Long displacement is a signed 32-bit address
// - Base register plus optional offset or displacement
// - Index scaled by 1/2/4/8/16 plus base, displacement
// - Scaled index plus displacement, no base
// - Instruction address plus displacement plus eight
// - Word-aligned fetch; displacement forms take two words
// - Opcode selects one of four instruction formats
package oag_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32; // Address and word width
  localparam int LIT_W = 5; // Ordinal literal field
  localparam int OFFSET_W = 12; // Short offset field
  localparam int OPERAND_W = 128; // Widest operand carried out

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [31:0] IP_BIAS = 32'h0000_0008; // Added in IP mode
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004; // One word
  localparam logic [31:0] TWO_WORD_BYTES = 32'h0000_0008; // Two words
  localparam logic [2:0] SCALE_CODE_MAX = 3'h4; // Code 4 means x16
  localparam logic [7:0] OPC_CTRL_LAST = 8'h1F; // Control range end
  localparam logic [7:0] OPC_CMPBR_LAST = 8'h3F; // Compare range end
  localparam logic [7:0] OPC_REG_LAST = 8'h7F; // Register range end
  localparam logic [31:0] FP_ONE_SINGLE = 32'h3F80_0000; // +1.0, 32b
  localparam logic [63:0] FP_ONE_DOUBLE = 64'h3FF0_0000_0000_0000;
  localparam logic [79:0] FP_ONE_EXT = 80'h3FFF_8000_0000_0000_0000;
  localparam logic [127:0] RESULT_RESET = 128'h0; // Idle operand

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_REGISTER = 2'b00,
    FMT_COMPARE_THEN_BRANCH = 2'b01,
    FMT_CONTROL = 2'b10,
    FMT_LOAD_STORE = 2'b11
  } fmt_t;

  typedef enum logic [3:0] {
    MODE_LITERAL = 4'b0000,
    MODE_REGISTER = 4'b0001,
    MODE_FP_LITERAL = 4'b0010,
    MODE_ABS_OFFSET = 4'b0011,
    MODE_ABS_DISP = 4'b0100,
    MODE_IND = 4'b0101,
    MODE_IND_OFFSET = 4'b0110,
    MODE_IND_DISP = 4'b0111,
    MODE_IND_INDEX = 4'b1000,
    MODE_IND_INDEX_DISP = 4'b1001,
    MODE_INDEX_DISP = 4'b1010,
    MODE_IP_DISP = 4'b1011
  } mode_t;

  typedef enum logic [1:0] {
    RC_GLOBAL = 2'b00,
    RC_LOCAL = 2'b01,
    RC_FLOAT = 2'b10
  } reg_class_t;

  typedef enum logic [1:0] {
    SZ_WORD = 2'b00,
    SZ_LONG = 2'b01,
    SZ_EXT = 2'b10,
    SZ_QUAD = 2'b11
  } size_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid; // Request present this cycle
    logic [31:0] instr_addr; // Address of the instruction
    logic [7:0] opcode; // Opcode field
    logic float_op; // Instruction is floating point
    size_t size; // Operand size
    mode_t mode; // Addressing mode
    reg_class_t reg_class; // Class of register operand
    logic [4:0] literal; // Ordinal literal value
    logic fp_one; // Float literal: 1 is +1.0, 0 is +0.0
    logic [11:0] offset; // Short offset field
    logic [31:0] disp; // Displacement word
    logic [2:0] scale; // Scale code 0..4
    logic [31:0] abase; // Base register value
    logic [31:0] index; // Index register value
  } req_t;

  typedef struct packed {
    logic misaligned; // Instruction not on a word boundary
    logic class_err; // Operand class not allowed here
    logic mode_err; // Mode not allowed for this format
    logic scale_err; // Scale code above x16
  } err_t;

  typedef struct packed {
    logic valid; // Result present
    fmt_t fmt; // Instruction format
    logic two_word; // Instruction carries a second word
    logic [31:0] next_ip; // Address of the following instruction
    logic lit_valid; // Operand holds an expanded literal
    logic [127:0] operand; // Expanded literal
    logic addr_valid; // Effective address is usable
    logic [31:0] eff_addr; // Effective address
    err_t err; // Error flags
  } res_t;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic fmt_t fmt_of(input logic [7:0] opcode);
    if (opcode <= OPC_CTRL_LAST) return FMT_CONTROL;
    if (opcode <= OPC_CMPBR_LAST) return FMT_COMPARE_THEN_BRANCH;
    if (opcode <= OPC_REG_LAST) return FMT_REGISTER;
    return FMT_LOAD_STORE;
  endfunction : fmt_of

  function automatic logic is_mem_mode(input mode_t mode);
    return (mode >= MODE_ABS_OFFSET) && (mode <= MODE_IP_DISP);
  endfunction : is_mem_mode

  // Displacement-carrying modes use the long displacement form
  function automatic logic is_long_form(input mode_t mode);
    return mode inside {MODE_ABS_DISP, MODE_IND_DISP,
      MODE_IND_INDEX_DISP, MODE_INDEX_DISP, MODE_IP_DISP};
  endfunction : is_long_form

endpackage : oag_pkg

/* File: logic/address_sum.sv */
// Effective-address adder for all memory addressing modes
`timescale 1ns/1ps
module address_sum (
  input oag_pkg::mode_t mode_i, // Addressing mode
  input logic [31:0] instr_addr_i, // Current instruction address
  input logic [11:0] offset_i, // Short offset
  input logic [31:0] disp_i, // Displacement word
  input logic [2:0] scale_i, // Scale code
  input logic [31:0] abase_i, // Base register value
  input logic [31:0] index_i, // Index register value
  output logic [31:0] eff_addr_o, // Wrapped effective address
  output logic scale_ok_o // Scale code is legal
);
  import oag_pkg::*;

  // ----------------------------------------------------------------
  // Terms
  // ----------------------------------------------------------------
  logic [31:0] base; // Base term
  logic [31:0] scaled; // Scaled index term
  logic [31:0] addend; // Offset or displacement term
  logic [31:0] offset_ext; // Offset with zero fill

  assign offset_ext = {{(ADDR_W-OFFSET_W){1'b0}}, offset_i};

  // Select the three terms per mode; unused ones stay zero
  always_comb begin
    base = '0;
    scaled = '0;
    addend = '0;
    unique case (mode_i)
      MODE_ABS_OFFSET: addend = offset_ext;
      MODE_ABS_DISP: addend = disp_i;
      MODE_IND: base = abase_i;
      MODE_IND_OFFSET: begin
        base = abase_i;
        addend = offset_ext;
      end
      MODE_IND_DISP: begin
        base = abase_i;
        addend = disp_i;
      end
      MODE_IND_INDEX: begin
        base = abase_i;
        scaled = index_i << scale_i;
      end
      MODE_IND_INDEX_DISP: begin
        base = abase_i;
        scaled = index_i << scale_i;
        addend = disp_i;
      end
      MODE_INDEX_DISP: begin
        scaled = index_i << scale_i;
        addend = disp_i;
      end
      MODE_IP_DISP: begin
        base = instr_addr_i + IP_BIAS;
        addend = disp_i;
      end
      // Literal and register modes form no address
      default: begin
      end
    endcase
  end

  // Plain 32-bit sum: carries out simply drop
  assign eff_addr_o = base + scaled + addend;
  assign scale_ok_o = (scale_i <= SCALE_CODE_MAX);

endmodule : address_sum

/* File: logic/operand_address_generator.sv */
// Operand expansion, class checks, format decode and address generation
`timescale 1ns/1ps
module operand_address_generator (
  input logic clock_i, // 40 MHz core clock
  input logic rstn_i, // Asynchronous reset, active low
  input oag_pkg::req_t req_i, // Decoded operand request
  output oag_pkg::res_t res_o // Registered result
);
  import oag_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  res_t state; // Whole registered state
  res_t next_state; // Value for the next edge

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  fmt_t fmt; // Format of this request
  logic mem_mode; // Mode is a memory mode
  logic long_form; // Displacement word follows
  logic mode_legal; // Mode code is defined
  logic [31:0] sum_addr; // Adder result
  logic scale_ok; // Scale code legal
  logic [127:0] fp_val; // Float literal at operand size
  logic fp_size_ok; // Size exists as a real format
  err_t err; // Errors for this request

  assign fmt = fmt_of(req_i.opcode);
  assign mem_mode = is_mem_mode(req_i.mode);
  assign long_form = is_long_form(req_i.mode);
  assign mode_legal = (req_i.mode <= MODE_IP_DISP);

  // Shared adder for every memory mode
  address_sum u_sum (
    .mode_i(req_i.mode),
    .instr_addr_i(req_i.instr_addr),
    .offset_i(req_i.offset),
    .disp_i(req_i.disp),
    .scale_i(req_i.scale),
    .abase_i(req_i.abase),
    .index_i(req_i.index),
    .eff_addr_o(sum_addr),
    .scale_ok_o(scale_ok)
  );

  // Float literal converted to the requested real size
  always_comb begin
    fp_val = '0;
    fp_size_ok = 1'b1;
    unique case (req_i.size)
      SZ_WORD: begin
        if (req_i.fp_one) begin
          fp_val = {{(OPERAND_W-32){1'b0}}, FP_ONE_SINGLE};
        end
      end
      SZ_LONG: begin
        if (req_i.fp_one) begin
          fp_val = {{(OPERAND_W-64){1'b0}}, FP_ONE_DOUBLE};
        end
      end
      SZ_EXT: begin
        if (req_i.fp_one) begin
          fp_val = {{(OPERAND_W-80){1'b0}}, FP_ONE_EXT};
        end
      end
      // No 128-bit real exists, so the literal has no encoding
      SZ_QUAD: fp_size_ok = 1'b0;
    endcase
  end

  // Error collection
  always_comb begin
    err = '0;
    // Fetch below word boundaries is never legal
    err.misaligned = (req_i.instr_addr[1:0] != 2'b00);
    // Float registers and float literals need a float instruction
    if (req_i.mode == MODE_REGISTER && req_i.reg_class == RC_FLOAT &&
        !req_i.float_op) begin
      err.class_err = 1'b1;
    end
    if (req_i.mode == MODE_FP_LITERAL &&
        (!req_i.float_op || !fp_size_ok)) begin
      err.class_err = 1'b1;
    end
    // Memory modes belong to load/store, the others to the rest
    if (!mode_legal || (mem_mode != (fmt == FMT_LOAD_STORE))) begin
      err.mode_err = 1'b1;
    end
    // Scale only matters where an index is used
    if (req_i.mode inside {MODE_IND_INDEX, MODE_IND_INDEX_DISP,
        MODE_INDEX_DISP} && !scale_ok) begin
      err.scale_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Next-state fill
  // ----------------------------------------------------------------
  // Results last one cycle; an idle cycle clears them so stale data
  // can never be mistaken for a fresh answer.
  always_comb begin
    next_state = '0;
    if (req_i.valid) begin
      next_state.valid = 1'b1;
      next_state.fmt = fmt;
      next_state.err = err;
      next_state.two_word = long_form;
      if (long_form) begin
        next_state.next_ip = req_i.instr_addr + TWO_WORD_BYTES;
      end else begin
        next_state.next_ip = req_i.instr_addr + WORD_BYTES;
      end
      // Anything wrong suppresses both operand and address
      if (err == '0) begin
        unique case (req_i.mode)
          MODE_LITERAL: begin
            // Zero fill at every size; never a sign copy
            next_state.lit_valid = 1'b1;
            next_state.operand =
              {{(OPERAND_W-LIT_W){1'b0}}, req_i.literal};
          end
          MODE_FP_LITERAL: begin
            next_state.lit_valid = 1'b1;
            next_state.operand = fp_val;
          end
          // Register operands are read by the register file
          MODE_REGISTER: next_state.lit_valid = 1'b0;
          default: begin
            next_state.addr_valid = 1'b1;
            next_state.eff_addr = sum_addr;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign res_o = state;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  logic clean_mem; // Memory request with no error
  logic clean_lit; // Literal request with no error
  assign clean_mem = req_i.valid && fmt == FMT_LOAD_STORE &&
    req_i.instr_addr[1:0] == 2'b00 && req_i.scale <= SCALE_CODE_MAX;
  assign clean_lit = req_i.valid && fmt != FMT_LOAD_STORE &&
    req_i.instr_addr[1:0] == 2'b00;

  chk_lit_widen: assert property (
    clean_lit && req_i.mode == MODE_LITERAL |=> res_o.lit_valid &&
    res_o.operand[31:0] == {27'h0, $past(req_i.literal)})
    else $error("literal not widened to 32 bits");

  chk_lit_wide_zero: assert property (
    clean_lit && req_i.mode == MODE_LITERAL && req_i.size != SZ_WORD
    |=> res_o.operand[127:32] == 96'h0)
    else $error("literal upper operand bits not zero");

  chk_lit_no_sign: assert property (
    clean_lit && req_i.mode == MODE_LITERAL && req_i.literal[4]
    |=> res_o.operand[31:5] == 27'h0 && res_o.operand[4])
    else $error("literal was sign extended");

  chk_fp_lit_class: assert property (
    req_i.valid && req_i.mode == MODE_FP_LITERAL && !req_i.float_op
    |=> res_o.err.class_err && !res_o.lit_valid)
    else $error("float literal accepted on non-float op");

  chk_fp_one_double: assert property (
    clean_lit && req_i.mode == MODE_FP_LITERAL && req_i.float_op &&
    req_i.fp_one && req_i.size == SZ_LONG
    |=> res_o.operand == {64'h0, FP_ONE_DOUBLE})
    else $error("float one at long size wrong");

  chk_float_reg: assert property (
    req_i.valid && req_i.mode == MODE_REGISTER &&
    req_i.reg_class == RC_FLOAT && !req_i.float_op
    |=> res_o.err.class_err)
    else $error("float register allowed on non-float op");

  chk_mode_format: assert property (
    req_i.valid && fmt == FMT_LOAD_STORE && !is_mem_mode(req_i.mode)
    |=> res_o.err.mode_err && !res_o.addr_valid && !res_o.lit_valid)
    else $error("non-memory mode accepted on load/store");

  chk_abs_offset: assert property (
    clean_mem && req_i.mode == MODE_ABS_OFFSET |=> res_o.addr_valid &&
    res_o.eff_addr == {20'h0_0000, $past(req_i.offset)})
    else $error("absolute offset address wrong");

  chk_abs_disp: assert property (
    clean_mem && req_i.mode == MODE_ABS_DISP
    |=> res_o.eff_addr == $past(req_i.disp) && res_o.two_word)
    else $error("absolute displacement address wrong");

  chk_base_offset: assert property (
    clean_mem && req_i.mode == MODE_IND_OFFSET |=> res_o.eff_addr ==
    $past(req_i.abase) + {20'h0_0000, $past(req_i.offset)})
    else $error("base plus offset address wrong");

  chk_scaled_index: assert property (
    clean_mem && req_i.mode == MODE_IND_INDEX_DISP |=> res_o.eff_addr ==
    $past(req_i.abase) + ($past(req_i.index) << $past(req_i.scale)) +
    $past(req_i.disp))
    else $error("indexed address wrong");

  chk_index_disp: assert property (
    clean_mem && req_i.mode == MODE_INDEX_DISP |=> res_o.eff_addr ==
    ($past(req_i.index) << $past(req_i.scale)) + $past(req_i.disp))
    else $error("index plus displacement wrong");

  chk_ip_relative: assert property (
    clean_mem && req_i.mode == MODE_IP_DISP |=> res_o.eff_addr ==
    $past(req_i.instr_addr) + $past(req_i.disp) + 32'h0000_0008)
    else $error("ip relative address wrong");

  chk_word_align: assert property (
    req_i.valid && req_i.instr_addr[1:0] != 2'b00
    |=> res_o.err.misaligned && !res_o.addr_valid)
    else $error("misaligned instruction not flagged");

  chk_format_map: assert property (
    req_i.valid |=> res_o.valid && res_o.fmt == fmt_of($past(req_i.opcode)))
    else $error("format decode mismatch");

  // Both instruction lengths step the next address by whole words
  chk_next_ip_long: assert property (
    req_i.valid && long_form |=> res_o.two_word &&
    res_o.next_ip == $past(req_i.instr_addr) + 32'h0000_0008)
    else $error("two-word next address wrong");

  chk_next_ip_short: assert property (
    req_i.valid && !long_form |=> !res_o.two_word &&
    res_o.next_ip == $past(req_i.instr_addr) + 32'h0000_0004)
    else $error("one-word next address wrong");

  // A misaligned fetch must not leak an operand either
  chk_misalign_lit: assert property (
    req_i.valid && req_i.instr_addr[1:0] != 2'b00
    |=> !res_o.lit_valid && res_o.operand == 128'h0)
    else $error("operand given for misaligned instruction");

  chk_fp_zero: assert property (
    req_i.valid && req_i.mode == MODE_FP_LITERAL && !req_i.fp_one
    |=> res_o.operand == 128'h0)
    else $error("float zero literal not zero");

  chk_fp_one_single: assert property (
    clean_lit && req_i.mode == MODE_FP_LITERAL && req_i.float_op &&
    req_i.fp_one && req_i.size == SZ_WORD
    |=> res_o.lit_valid && res_o.operand == {96'h0, FP_ONE_SINGLE})
    else $error("float one at word size wrong");

  // No 128-bit real exists, so the literal must be refused there
  chk_fp_quad_refused: assert property (
    req_i.valid && req_i.mode == MODE_FP_LITERAL && req_i.size == SZ_QUAD
    |=> res_o.err.class_err && !res_o.lit_valid)
    else $error("float literal accepted at quad size");

  chk_global_local_reg: assert property (
    req_i.valid && req_i.mode == MODE_REGISTER &&
    req_i.reg_class != RC_FLOAT |=> !res_o.err.class_err)
    else $error("global or local register refused");

  // Register operands are read elsewhere; nothing is produced here
  chk_reg_no_value: assert property (
    req_i.valid && req_i.mode == MODE_REGISTER
    |=> !res_o.lit_valid && !res_o.addr_valid)
    else $error("register operand produced a value");

  // Address modes on non-memory formats are refused outright
  chk_mem_mode_format: assert property (
    req_i.valid && fmt != FMT_LOAD_STORE && is_mem_mode(req_i.mode)
    |=> res_o.err.mode_err && !res_o.addr_valid)
    else $error("memory mode accepted on non-memory format");

  chk_base_only: assert property (
    clean_mem && req_i.mode == MODE_IND
    |=> res_o.addr_valid && res_o.eff_addr == $past(req_i.abase))
    else $error("base register address wrong");

  chk_base_index: assert property (
    clean_mem && req_i.mode == MODE_IND_INDEX |=> res_o.eff_addr ==
    $past(req_i.abase) + ($past(req_i.index) << $past(req_i.scale)))
    else $error("base plus scaled index wrong");

  // Codes above x16 have no scale factor, so no address may leave
  chk_scale_refused: assert property (
    req_i.valid && req_i.scale > SCALE_CODE_MAX && req_i.mode inside
    {MODE_IND_INDEX, MODE_IND_INDEX_DISP, MODE_INDEX_DISP}
    |=> res_o.err.scale_err && !res_o.addr_valid)
    else $error("illegal scale code accepted");

endmodule : operand_address_generator

/* File: test/oag_mem_sink.sv */
// Load/store unit stand-in that takes effective addresses from the block
`timescale 1ns/1ps
module oag_mem_sink
  import oag_pkg::*;
(
  input wire logic clock_i, // Core clock
  input wire logic rstn_i, // Asynchronous reset, active low
  input wire oag_pkg::res_t res_i, // Result from the generator
  output int n_mem_o // Addresses accepted so far
);
  // ----------------------------------------------------------------
  // Address intake
  // ----------------------------------------------------------------
  logic [31:0] addr_q[$]; // Addresses in arrival order

  // Takes every usable address; the unit never stalls the generator
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      n_mem_o <= 0;
    end else if (res_i.valid === 1'b1 && res_i.addr_valid === 1'b1) begin
      addr_q.push_back(res_i.eff_addr);
      n_mem_o <= n_mem_o + 1;
    end
  end
endmodule : oag_mem_sink

/* File: test/operand_address_generator_tb.sv */
// Self-checking bench for the operand and address generator
`timescale 1ns/1ps
module operand_address_generator_tb;
  import oag_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_i = 1'b0; // 40 MHz clock
  logic rstn_i = 1'b0; // Reset, active low
  req_t req_i = '0; // Request to the block
  res_t res_o; // Result from the block
  res_t exp_prev = '0; // Expected result of the last edge
  req_t b; // Scratch request
  int n_errors = 0; // Mismatches
  int num_checks = 0; // Comparisons made
  int n_mem; // Addresses seen by the sink
  int n_mem_exp = 0; // Addresses the model expects

  always #12.5 clock_i = ~clock_i;

  operand_address_generator dut (.clock_i(clock_i), .rstn_i(rstn_i),
    .req_i(req_i), .res_o(res_o));
  oag_mem_sink sink (.clock_i(clock_i), .rstn_i(rstn_i), .res_i(res_o),
    .n_mem_o(n_mem));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  // Written from the addressing rules, independent of the package helpers
  function automatic res_t model(input req_t r);
    res_t e;
    int m;
    logic mem;
    logic [31:0] sc;
    e = '0;
    if (r.valid !== 1'b1) return e;
    m = r.mode;
    e.valid = 1'b1;
    if (r.opcode <= 8'h1F) e.fmt = FMT_CONTROL;
    else if (r.opcode <= 8'h3F) e.fmt = FMT_COMPARE_THEN_BRANCH;
    else if (r.opcode <= 8'h7F) e.fmt = FMT_REGISTER;
    else e.fmt = FMT_LOAD_STORE;
    e.two_word = m inside {4, 7, 9, 10, 11};
    e.next_ip = r.instr_addr + (e.two_word ? 32'h0000_0008 : 32'h0000_0004);
    mem = (m >= 3) && (m <= 11);
    e.err.misaligned = r.instr_addr[1:0] != 2'b00;
    e.err.class_err = (m == 1 && r.reg_class == RC_FLOAT && !r.float_op)
      || (m == 2 && (!r.float_op || r.size == SZ_QUAD));
    e.err.mode_err = m > 11 || (mem && e.fmt != FMT_LOAD_STORE)
      || (m < 3 && e.fmt == FMT_LOAD_STORE);
    e.err.scale_err = r.scale > 3'h4 && m inside {8, 9, 10};
    if (e.err != 4'h0) return e;
    sc = r.index << r.scale;
    e.lit_valid = m == 0 || m == 2;
    e.addr_valid = mem;
    case (m)
      0: e.operand = {123'h0, r.literal};
      2: if (r.fp_one) begin
        case (r.size)
          SZ_WORD: e.operand = {96'h0, FP_ONE_SINGLE};
          SZ_LONG: e.operand = {64'h0, FP_ONE_DOUBLE};
          default: e.operand = {48'h0, FP_ONE_EXT};
        endcase
      end
      3: e.eff_addr = {20'h0, r.offset};
      4: e.eff_addr = r.disp;
      5: e.eff_addr = r.abase;
      6: e.eff_addr = r.abase + {20'h0, r.offset};
      7: e.eff_addr = r.abase + r.disp;
      8: e.eff_addr = r.abase + sc;
      9: e.eff_addr = r.abase + sc + r.disp;
      10: e.eff_addr = sc + r.disp;
      11: e.eff_addr = r.instr_addr + 32'h0000_0008 + r.disp;
      default: e.eff_addr = 32'h0000_0000;
    endcase
    return e;
  endfunction : model

  // ----------------------------------------------------------------
  // Driving and checking
  // ----------------------------------------------------------------
  // Present one request and check the answer to the previous one
  task automatic step(input req_t r);
    @(posedge clock_i);
    req_i <= r;
    #1;
    num_checks++;
    if (res_o !== exp_prev) begin
      n_errors++;
      $display("[FAIL] %0t result %h expected %h", $time, res_o, exp_prev);
    end
    exp_prev = model(r);
    if (exp_prev.addr_valid) n_mem_exp++;
  endtask : step

  // Random request with mostly legal mode and format pairs
  function automatic req_t rnd();
    req_t r;
    int m;
    r = '0;
    m = $urandom % 16;
    r.valid = ($urandom % 8) != 0;
    r.mode = mode_t'(m);
    r.opcode = ((m >= 3) ? 8'h80 : 8'h40) | 8'($urandom % 64);
    if ($urandom % 5 == 0) r.opcode = 8'($urandom);
    r.instr_addr = ($urandom % 9 == 0) ? $urandom : $urandom & ~32'h3;
    r.float_op = 1'($urandom);
    r.size = size_t'($urandom % 4);
    r.reg_class = (m == 1) ? reg_class_t'($urandom % 3) : RC_GLOBAL;
    r.literal = 5'($urandom);
    r.fp_one = 1'($urandom);
    r.offset = 12'($urandom);
    r.disp = $urandom;
    r.scale = 3'($urandom % 6);
    r.abase = $urandom;
    r.index = $urandom;
    return r;
  endfunction : rnd

  // Report counts and give the verdict
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    $display("[FAIL] %0t run did not finish", $time);
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(95));
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    b = '0;
    b.valid = 1'b1;
    b.opcode = 8'h80;
    b.mode = MODE_IP_DISP;
    b.instr_addr = 32'h0000_0100;
    b.disp = 32'h0000_0010;
    step(b);
    step('0);
    b = rnd();
    b.valid = 1'b1;
    b.instr_addr = 32'h0000_0200;
    b.opcode = 8'h40;
    b.mode = MODE_LITERAL;
    b.literal = 5'h1F;
    for (int s = 0; s < 4; s++) begin
      b.size = size_t'(s);
      step(b);
    end
    b.mode = MODE_FP_LITERAL;
    for (int k = 0; k < 16; k++) begin
      {b.float_op, b.fp_one, b.size} = 4'(k);
      step(b);
    end
    b.mode = MODE_REGISTER;
    for (int k = 0; k < 6; k++) begin
      b.reg_class = reg_class_t'(k % 3);
      b.float_op = 1'(k / 3);
      step(b);
    end
    for (int k = 0; k < 32; k++) begin
      b.mode = mode_t'(k % 16);
      b.opcode = (k < 16) ? 8'h47 : 8'h9C;
      step(b);
    end
    b.index = 32'h1234_5679;
    for (int k = 0; k < 24; k++) begin
      b.mode = mode_t'(8 + k / 8);
      b.scale = 3'(k % 8);
      step(b);
    end
    b.scale = 3'h2;
    b.mode = MODE_ABS_OFFSET;
    b.offset = 12'h800;
    step(b);
    b.offset = 12'hFFF;
    step(b);
    b.mode = MODE_ABS_DISP;
    b.disp = 32'h8000_0000;
    step(b);
    b.mode = MODE_IND_DISP;
    b.abase = 32'hFFFF_FFF0;
    b.disp = 32'h0000_0020;
    step(b);
    b.mode = MODE_IP_DISP;
    b.instr_addr = 32'hFFFF_FFFC;
    step(b);
    b.instr_addr = 32'h0000_0102;
    step(b);
    b.mode = MODE_REGISTER;
    b.instr_addr = 32'h0000_0104;
    for (int k = 0; k < 8; k++) begin
      b.opcode = 8'((k % 2) ? (32'h20 << (k / 2)) - 1
        : (32'h10 << (k / 2)) & ~32'h10);
      step(b);
    end
    repeat (400) step(rnd());
    @(posedge clock_i);
    rstn_i <= 1'b0;
    req_i <= '0;
    #1;
    num_checks++;
    if (res_o !== '0) begin
      n_errors++;
      $display("[FAIL] %0t result not cleared by reset", $time);
    end
    exp_prev = '0;
    n_mem_exp = 0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (100) step(rnd());
    step('0);
    step('0);
    num_checks++;
    if (n_mem !== n_mem_exp) begin
      n_errors++;
      $display("[FAIL] %0t sink count wrong", $time);
    end
    test_done();
  end
endmodule : operand_address_generator_tb
